// ### cpms_pkg.sv
// Shared constants of the codec power-mode sequencer
package cpms_pkg;
	localparam int CLK_HZ       = 10_000_000;
	localparam int INIT_TIME_US = 1000;
	localparam int WAKE_TIME_US = 1000;
	localparam int INIT_CYC     = INIT_TIME_US * (CLK_HZ / 1_000_000);
	localparam int WAKE_CYC     = WAKE_TIME_US * (CLK_HZ / 1_000_000);
	localparam int LOSS_TIME_NS = 4000;
	localparam int LOSS_CYC     = (LOSS_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int RAMP_FRAMES  = 16;
	localparam int PD_FRAMES    = 16;
	localparam int NUM_SLOTS    = 8;
	localparam int ADDR_W       = 10;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SOFT_RESET = 8'h01;
	localparam logic [7:0] IDX_SLEEP      = 8'h02;
	localparam logic [7:0] IDX_REC_SLOT0  = 8'h1e;
	localparam logic [7:0] IDX_PLAY_SLOT0 = 8'h28;
	localparam logic [7:0] IDX_IN_EN      = 8'h76;
	localparam logic [7:0] IDX_CH_PWR     = 8'h78;
	localparam logic [7:0] IDX_STATUS     = 8'h7a;

	localparam int SLEEP_BIT   = 0;
	localparam int SOFT_BIT    = 0;
	localparam int SLOT_EN_BIT = 7;
	localparam int PB_RIGHT_BIT = 0;
	localparam int PWR_ADC_BIT = 7;
	localparam int PWR_DAC_BIT = 6;
	localparam int PWR_MIC_BIT = 5;
	localparam int STAT_LSB    = 5;

	localparam logic [7:0] IN_EN_RST  = 8'h00;
	localparam logic [7:0] CH_PWR_RST = 8'h00;
	localparam logic [7:0] SLOT_RST   = 8'h00;

	localparam logic [2:0] ST_INIT   = 3'b111;
	localparam logic [2:0] ST_SLEEP  = 3'b100;
	localparam logic [2:0] ST_WAKE   = 3'b010;
	localparam logic [2:0] ST_ACTIVE = 3'b001;
	localparam logic [2:0] ST_RAMP   = 3'b011;
	localparam logic [2:0] ST_PWRDN  = 3'b101;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [3:0] VOL_MAX     = 4'hf;
endpackage

// ### cpms_int_if.sv
// Internal carrier between the sequencer core, pin synchroniser and volume ramp
interface cpms_int_if;
	logic       fs_rise;
	logic       bclk_rise;
	logic       bclk_fall;
	logic       sdin_bit;
	logic       clk_ok;
	logic       ramp_up;
	logic       ramp_down;
	logic       ramp_done;
	logic [3:0] vol;
	modport pins (output fs_rise, bclk_rise, bclk_fall, sdin_bit, clk_ok);
	modport ramp (input fs_rise, clk_ok, ramp_up, ramp_down, output vol, ramp_done);
	modport core (input fs_rise, bclk_rise, bclk_fall, sdin_bit, clk_ok, vol, ramp_done,
		output ramp_up, ramp_down);
endinterface

// ### cpms_pin_sync.sv
// Synchroniser and edge finder for the audio frame, bit clock and playback pins
module cpms_pin_sync
	import cpms_pkg::*;
(
	input  logic aclk,
	input  logic aresetn,
	input  logic frame_sync,
	input  logic bit_clk,
	input  logic playback_data_in,
	cpms_int_if.pins p
);
	logic [2:0] meta;
	logic [2:0] sync;
	logic       fs_q;
	logic       bc_q;
	logic [5:0] loss_cnt;

	// Runs through reset so the edge finder starts at the pin's idle level; zeros would fake an edge
	always_ff @(posedge aclk) begin
		meta <= {frame_sync, bit_clk, playback_data_in};
		sync <= meta;
	end

	always_ff @(posedge aclk) begin
		fs_q <= sync[2];
		bc_q <= sync[1];
	end

	assign p.fs_rise   = sync[2] & ~fs_q;
	assign p.bclk_rise = sync[1] & ~bc_q;
	assign p.bclk_fall = ~sync[1] & bc_q;
	assign p.sdin_bit  = sync[0];

	// A stopped bit clock drops clk_ok so ramps and power-down never hang
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loss_cnt <= 6'h00;
			p.clk_ok <= 1'b0;
		end else if (p.bclk_rise || p.bclk_fall) begin
			loss_cnt <= 6'h00;
			p.clk_ok <= 1'b1;
		end else if (loss_cnt == 6'(LOSS_CYC - 1)) begin
			p.clk_ok <= 1'b0;
		end else begin
			loss_cnt <= loss_cnt + 6'h01;
		end
	end
endmodule

// ### cpms_vol_ramp.sv
// Frame-paced playback volume ramp
module cpms_vol_ramp
	import cpms_pkg::*;
(
	input  logic aclk,
	input  logic aresetn,
	cpms_int_if.ramp r
);
	logic [7:0] fcnt;
	logic       step;

	// Without clocks there is nothing to play, so the ramp moves one step on every system clock cycle
	assign step = !r.clk_ok || (r.fs_rise && fcnt == 8'(RAMP_FRAMES - 1));
	assign r.ramp_done = (r.vol == 4'h0);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fcnt <= 8'h00;
		end else if (r.fs_rise) begin
			fcnt <= (fcnt == 8'(RAMP_FRAMES - 1)) ? 8'h00 : fcnt + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r.vol <= 4'h0;
		end else if (step && r.ramp_down && r.vol != 4'h0) begin
			r.vol <= r.vol - 4'h1;
		end else if (step && r.ramp_up && r.vol != VOL_MAX) begin
			r.vol <= r.vol + 4'h1;
		end
	end

	property p_vol_step;
		@(posedge aclk) disable iff (!aresetn)
		(r.vol != $past(r.vol)) |-> (r.vol == 4'($past(r.vol) + 4'h1)) || (r.vol == 4'($past(r.vol) - 4'h1));
	endproperty
	a_vol_step: assert property (p_vol_step) else $error("volume jumped by more than one step");
endmodule

// ### cpms_sequencer.sv
// Codec power-mode sequencer with AXI4-Lite registers and TDM audio port
// Overview of operation
// - After power-up wait 1 ms initialising registers, then settle in sleep.
// - Clearing the sleep control starts the internal wake-up sequence.
// - Only inputs enabled in the input channel enable register are recorded.
// - Eight playback and eight record slot registers gate serial slots.
// - Channel power register brings up only requested ADC, DAC, microphone bias.
// - With clocks and power, record data goes out, playback drives line outputs.
// - Setting sleep control ramps volume down then powers all blocks down.
// - Status field bits 7:5 report progress; 100 means clocks may stop.
// - Sleep keeps every register value for a clock-only resume.
// - Supply power-down allows 10 ms for ramp, block power-down, shutdown.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
module cpms_sequencer
	import cpms_pkg::*;
#(
	parameter int INIT_CYCLES = INIT_CYC,
	parameter int WAKE_CYCLES = WAKE_CYC
)(
	input  logic              aclk,
	input  logic              aresetn,
	input  logic [ADDR_W-1:0] s_axi_awaddr,
	input  logic              s_axi_awvalid,
	output logic              s_axi_awready,
	input  logic [31:0]       s_axi_wdata,
	input  logic [3:0]        s_axi_wstrb,
	input  logic              s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  logic              s_axi_bready,
	input  logic [ADDR_W-1:0] s_axi_araddr,
	input  logic              s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  logic              s_axi_rready,
	input  logic              frame_sync,
	input  logic              bit_clk,
	input  logic              playback_data_in,
	output logic              record_data_out,
	output logic              record_data_oe,
	input  logic [63:0]       adc_data,
	output logic [15:0]       dac_left,
	output logic [15:0]       dac_right,
	output logic              adc_power_en,
	output logic              dac_power_en,
	output logic              microphone_bias_en
);
	typedef enum logic [2:0] {S_INIT, S_SLEEP, S_WAKE, S_ACTIVE, S_RAMP, S_PWRDN} cpms_state_t;

	cpms_state_t state;
	logic [15:0] cnt;
	logic        sleep_req;
	logic [7:0]  in_en;
	logic [7:0]  ch_pwr;
	logic [7:0]  rec_slot  [NUM_SLOTS];
	logic [7:0]  play_slot [NUM_SLOTS];
	logic        aw_full;
	logic        w_full;
	logic [7:0]  aw_idx;
	logic [7:0]  w_byte;
	logic        w_lane0;
	logic        wr_fire;
	logic        wr_ok;
	logic        soft_rst;
	logic [2:0]  status;
	logic        audio_on;
	logic [7:0]  bit_cnt;
	logic [7:0]  tx_idx;
	logic [2:0]  tx_slot;
	logic [1:0]  tx_ch;
	logic [15:0] tx_smp;
	logic        tx_on;
	logic [2:0]  rx_slot;
	logic [15:0] rx_sh;
	logic [15:0] pb_l;
	logic [15:0] pb_r;

	cpms_int_if p ();

	cpms_pin_sync u_pins (
		.aclk             (aclk),
		.aresetn          (aresetn),
		.frame_sync       (frame_sync),
		.bit_clk          (bit_clk),
		.playback_data_in (playback_data_in),
		.p                (p)
	);

	cpms_vol_ramp u_ramp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.r       (p)
	);

	function automatic logic in_win(input logic [7:0] idx, input logic [7:0] base);
		return (idx >= base) && (8'(idx - base) < 8'(NUM_SLOTS));
	endfunction

	function automatic logic [2:0] win_ofs(input logic [7:0] idx, input logic [7:0] base);
		return 3'(idx - base);
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		return idx == IDX_SOFT_RESET || idx == IDX_SLEEP || idx == IDX_IN_EN || idx == IDX_CH_PWR
			|| idx == IDX_STATUS || in_win(idx, IDX_REC_SLOT0) || in_win(idx, IDX_PLAY_SLOT0);
	endfunction

	function automatic logic [2:0] st_code(input cpms_state_t s);
		case (s)
			S_INIT:   return ST_INIT;
			S_SLEEP:  return ST_SLEEP;
			S_WAKE:   return ST_WAKE;
			S_ACTIVE: return ST_ACTIVE;
			S_RAMP:   return ST_RAMP;
			S_PWRDN:  return ST_PWRDN;
			default:  return ST_INIT;
		endcase
	endfunction

	function automatic logic [15:0] scale(input logic [15:0] s, input logic [3:0] v);
		return (v == 4'h0) ? 16'h0000 : 16'($signed(s) >>> (VOL_MAX - v));
	endfunction

	assign status   = st_code(state);
	assign wr_fire  = aw_full && w_full && !s_axi_bvalid;
	assign wr_ok    = wr_fire && w_lane0;
	assign soft_rst = wr_ok && aw_idx == IDX_SOFT_RESET && w_byte[SOFT_BIT] && state != S_INIT;
	assign audio_on = (state == S_ACTIVE || state == S_RAMP) && p.clk_ok;
	assign p.ramp_up   = (state == S_ACTIVE);
	assign p.ramp_down = (state != S_ACTIVE);

	// Power-mode sequence
	always_ff @(posedge aclk) begin
		if (!aresetn || soft_rst) begin
			state <= S_INIT;
			cnt   <= 16'h0000;
		end else begin
			case (state)
				S_INIT: begin
					if (cnt == 16'(INIT_CYCLES - 1)) begin
						state <= S_SLEEP;
						cnt   <= 16'h0000;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				S_SLEEP: begin
					if (!sleep_req) begin
						state <= S_WAKE;
						cnt   <= 16'h0000;
					end
				end
				S_WAKE: begin
					if (sleep_req) begin
						state <= S_RAMP;
					end else if (cnt == 16'(WAKE_CYCLES - 1)) begin
						state <= S_ACTIVE;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				S_ACTIVE: begin
					if (sleep_req) begin
						state <= S_RAMP;
					end
				end
				S_RAMP: begin
					if (p.ramp_done) begin
						state <= S_PWRDN;
						cnt   <= 16'h0000;
					end
				end
				S_PWRDN: begin
					if (cnt == 16'(PD_FRAMES - 1)) begin
						state <= S_SLEEP;
					end else if (p.fs_rise || !p.clk_ok) begin
						cnt <= cnt + 16'h0001;
					end
				end
				default: state <= S_INIT;
			endcase
		end
	end

	// Registers: held at defaults through initialisation, untouched by sleep
	always_ff @(posedge aclk) begin
		if (!aresetn || state == S_INIT) begin
			sleep_req <= 1'b1;
			in_en     <= IN_EN_RST;
			ch_pwr    <= CH_PWR_RST;
			for (int k = 0; k < NUM_SLOTS; k++) begin
				rec_slot[k]  <= SLOT_RST;
				play_slot[k] <= SLOT_RST;
			end
		end else if (wr_ok) begin
			if (aw_idx == IDX_SLEEP)
				sleep_req <= w_byte[SLEEP_BIT];
			if (aw_idx == IDX_IN_EN)
				in_en <= w_byte;
			if (aw_idx == IDX_CH_PWR)
				ch_pwr <= w_byte;
			if (in_win(aw_idx, IDX_REC_SLOT0))
				rec_slot[win_ofs(aw_idx, IDX_REC_SLOT0)] <= w_byte;
			if (in_win(aw_idx, IDX_PLAY_SLOT0))
				play_slot[win_ofs(aw_idx, IDX_PLAY_SLOT0)] <= w_byte;
		end
	end

	// Write address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			aw_idx        <= 8'h00;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full       <= 1'b1;
			aw_idx        <= s_axi_awaddr[ADDR_W-1:2];
			s_axi_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_full <= 1'b0;
		end else if (!aw_full && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full       <= 1'b0;
			w_byte       <= 8'h00;
			w_lane0      <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full       <= 1'b1;
			w_byte       <= s_axi_wdata[7:0];
			w_lane0      <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end else if (wr_fire) begin
			w_full <= 1'b0;
		end else if (!w_full && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_byte(s_axi_araddr[ADDR_W-1:2])};
			s_axi_rresp   <= is_mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	function automatic logic [7:0] rd_byte(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == IDX_SLEEP)
			v[SLEEP_BIT] = sleep_req;
		else if (idx == IDX_IN_EN)
			v = in_en;
		else if (idx == IDX_CH_PWR)
			v = ch_pwr;
		else if (idx == IDX_STATUS)
			v[STAT_LSB +: 3] = status;
		else if (in_win(idx, IDX_REC_SLOT0))
			v = rec_slot[win_ofs(idx, IDX_REC_SLOT0)];
		else if (in_win(idx, IDX_PLAY_SLOT0))
			v = play_slot[win_ofs(idx, IDX_PLAY_SLOT0)];
		return v;
	endfunction

	// Block power follows the request only while awake; ramp keeps it on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adc_power_en       <= 1'b0;
			dac_power_en       <= 1'b0;
			microphone_bias_en <= 1'b0;
		end else begin
			adc_power_en       <= (state == S_ACTIVE || state == S_RAMP) && ch_pwr[PWR_ADC_BIT];
			dac_power_en       <= (state == S_ACTIVE || state == S_RAMP) && ch_pwr[PWR_DAC_BIT];
			microphone_bias_en <= (state == S_ACTIVE || state == S_RAMP) && ch_pwr[PWR_MIC_BIT];
		end
	end

	// Slot timing: 32 bit clocks per slot, sample MSB first in the first 16
	always_ff @(posedge aclk) begin
		if (!aresetn)
			bit_cnt <= 8'h00;
		else if (p.fs_rise)
			bit_cnt <= 8'h00;
		else if (p.bclk_rise)
			bit_cnt <= bit_cnt + 8'h01;
	end

	always_comb begin
		tx_idx  = p.fs_rise ? 8'h00 : bit_cnt;
		tx_slot = tx_idx[7:5];
		tx_ch   = rec_slot[tx_slot][1:0];
		tx_smp  = in_en[tx_ch] ? adc_data[{tx_ch, 4'h0} +: 16] : 16'h0000;
		tx_on   = audio_on && adc_power_en && rec_slot[tx_slot][SLOT_EN_BIT];
	end

	// Record data launched on the falling bit clock, released off-slot
	always_ff @(posedge aclk) begin
		if (!aresetn || !audio_on) begin
			record_data_out <= 1'b0;
			record_data_oe  <= 1'b0;
		end else if (p.bclk_fall) begin
			record_data_oe  <= tx_on;
			record_data_out <= tx_on && !tx_idx[4] && tx_smp[~tx_idx[3:0]];
		end
	end

	assign rx_slot = bit_cnt[7:5];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_sh <= 16'h0000;
			pb_l  <= 16'h0000;
			pb_r  <= 16'h0000;
		end else if (p.bclk_rise && audio_on && play_slot[rx_slot][SLOT_EN_BIT] && !bit_cnt[4]) begin
			rx_sh <= {rx_sh[14:0], p.sdin_bit};
			if (bit_cnt[3:0] == 4'hf && play_slot[rx_slot][PB_RIGHT_BIT])
				pb_r <= {rx_sh[14:0], p.sdin_bit};
			else if (bit_cnt[3:0] == 4'hf)
				pb_l <= {rx_sh[14:0], p.sdin_bit};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dac_left  <= 16'h0000;
			dac_right <= 16'h0000;
		end else begin
			dac_left  <= dac_power_en ? scale(pb_l, p.vol) : 16'h0000;
			dac_right <= dac_power_en ? scale(pb_r, p.vol) : 16'h0000;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_init_exit;
		$fell(state == S_INIT) |-> $past(cnt) == 16'(INIT_CYCLES - 1) && state == S_SLEEP;
	endproperty
	a_init_exit: assert property (p_init_exit) else $error("initialisation left early");
	property p_wake;
		(state == S_SLEEP && !sleep_req && !soft_rst) |=> state == S_WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("wake request not followed");
	property p_wake_len;
		$rose(state == S_ACTIVE) |-> $past(state) == S_WAKE && $past(cnt) == 16'(WAKE_CYCLES - 1);
	endproperty
	a_wake_len: assert property (p_wake_len) else $error("wake sequence length wrong");
	property p_rec_only;
		(p.bclk_fall && audio_on && !in_en[tx_ch]) |=> !record_data_out;
	endproperty
	a_rec_only: assert property (p_rec_only) else $error("disabled input recorded");
	property p_slot_gate;
		(p.bclk_fall && !tx_on) |=> !record_data_oe;
	endproperty
	a_slot_gate: assert property (p_slot_gate) else $error("record driven in disabled slot");
	property p_pwr_req;
		(state == S_ACTIVE && !ch_pwr[PWR_ADC_BIT]) |=> !adc_power_en;
	endproperty
	a_pwr_req: assert property (p_pwr_req) else $error("converter powered unrequested");
	property p_dac_quiet;
		!dac_power_en |=> dac_left == 16'h0000 && dac_right == 16'h0000;
	endproperty
	a_dac_quiet: assert property (p_dac_quiet) else $error("line output active unpowered");
	property p_ramp_first;
		(state == S_ACTIVE && sleep_req && !soft_rst) |=> state == S_RAMP ##1 state != S_SLEEP;
	endproperty
	a_ramp_first: assert property (p_ramp_first) else $error("sleep skipped the ramp");
	property p_pwr_off;
		state == S_SLEEP |=> !adc_power_en && !dac_power_en && !microphone_bias_en;
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("block powered in sleep");
	property p_status;
		(state == S_SLEEP) == (status == ST_SLEEP);
	endproperty
	a_status: assert property (p_status) else $error("status disagrees with sleep");
	property p_retain;
		(state == S_SLEEP && !wr_fire) |=> $stable(ch_pwr) && $stable(in_en) && $stable(rec_slot[0]);
	endproperty
	a_retain: assert property (p_retain) else $error("register lost in sleep");
	property p_pd_len;
		(state == S_PWRDN ##1 state == S_SLEEP) |-> $past(cnt) == 16'(PD_FRAMES - 1);
	endproperty
	a_pd_len: assert property (p_pd_len) else $error("power-down too short");
	property p_soft;
		soft_rst |=> state == S_INIT ##1 (sleep_req && ch_pwr == CH_PWR_RST && in_en == IN_EN_RST);
	endproperty
	a_soft: assert property (p_soft) else $error("software reset incomplete");

	c_wake: cover property ($rose(state == S_ACTIVE));
	c_sleep: cover property (state == S_PWRDN ##1 state == S_SLEEP);
	c_soft: cover property (soft_rst);
	c_tx: cover property ($rose(record_data_oe));
endmodule

// ### cpms_host_model.sv
// Host-side audio port model: frame and bit clocks, playback data, record capture
module cpms_host_model (
	input  wire logic        run,
	input  wire logic [15:0] pb_word,
	input  wire logic        record_data_out,
	input  wire logic        record_data_oe,
	output logic             frame_sync,
	output logic             bit_clk,
	output logic             playback_data_in,
	output logic [15:0]      rec_word,
	output int               oe_cnt,
	output int               frames
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] acc;
	int          n;
	initial begin
		frame_sync = 1'b0;
		bit_clk = 1'b1;
		playback_data_in = 1'b0;
		rec_word = 16'h0;
		oe_cnt = 0;
		frames = 0;
		forever begin
			// Step off the system clock edge once, so pin changes never race its sampling
			if (!run) begin
				wait (run);
				#20;
			end
			n = 0;
			// Whole frames only; the clock idles high between them
			for (int b = 0; b < 256; b++) begin
				bit_clk = 1'b0;
				frame_sync = (b < 4);
				playback_data_in = (b < 16) ? pb_word[15-b] : 1'b0;
				#400;
				bit_clk = 1'b1;
				#400;
				// Sampled late in the bit: the device output lags the pin edge by a few cycles
				if (record_data_oe === 1'b1) n++;
				if (b < 16) acc = {acc[14:0], record_data_out};
			end
			// Released line shows no stale value
			playback_data_in = ~playback_data_in;
			rec_word = acc;
			oe_cnt = n;
			frames++;
		end
	end
endmodule

// ### cpms_sequencer_tb.sv
// Self-checking bench for the codec power-mode sequencer
module cpms_sequencer_tb
	import cpms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
	logic        awready, wready, bvalid, arready, rvalid, fs, bck, pb, rec, rec_oe;
	logic        adc_en, dac_en, mic_en;
	logic [9:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, got;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [15:0] rec_word, dl, dr;
	logic [63:0] adc_data;
	int          err_count = 0;
	int          checks = 0;
	int          cyc = 0;
	int          frames, oe_cnt;

	cpms_sequencer #(.INIT_CYCLES(20), .WAKE_CYCLES(20)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.frame_sync(fs), .bit_clk(bck), .playback_data_in(pb), .record_data_out(rec),
		.record_data_oe(rec_oe), .adc_data(adc_data), .dac_left(dl), .dac_right(dr),
		.adc_power_en(adc_en), .dac_power_en(dac_en), .microphone_bias_en(mic_en)
	);
	cpms_host_model u_host (
		.run(run), .pb_word(16'h7001), .record_data_out(rec), .record_data_oe(rec_oe),
		.frame_sync(fs), .bit_clk(bck), .playback_data_in(pb), .rec_word(rec_word),
		.oe_cnt(oe_cnt), .frames(frames)
	);

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
		int n;
		n = 0;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Each channel released at its own handshake edge
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 300);
		resp = bresp;
		chk("write answer", 1, bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] idx);
		int n;
		n = 0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 300);
		got = rdata;
		chk("read answer", 1, rvalid);
		resp = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic poll(input logic [2:0] st);
		int n;
		n = 0;
		do begin
			rd(IDX_STATUS);
			n++;
		end while (got[7:5] !== st && n < 400);
		chk("status", st, got[7:5]);
	endtask

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Hang guard, well above the five frames the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			report_and_stop();
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, run} = 7'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		adc_data = {16'h1111, 16'h9c3a, 16'h2222, 16'h5a5a};
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(IDX_STATUS);
		chk("init status", ST_INIT, got[7:5]);
		wr(IDX_IN_EN, 8'h0f, 4'h1);
		poll(ST_SLEEP);
		rd(IDX_IN_EN);
		chk("enable after init", IN_EN_RST, got);
		rd(IDX_SLEEP);
		chk("sleep default", 8'h01, got);
		rd(8'h50);
		chk("unmapped read", RESP_SLVERR, resp);
		wr(IDX_IN_EN, 8'h04, 4'h1);
		wr(IDX_REC_SLOT0, 8'h82, 4'h1);
		wr(IDX_PLAY_SLOT0, 8'h80, 4'h1);
		wr(IDX_SLEEP, 8'h00, 4'h1);
		rd(IDX_STATUS);
		chk("waking", ST_WAKE, got[7:5]);
		poll(ST_ACTIVE);
		for (int i = 0; i < 3; i++) begin
			wr(IDX_CH_PWR, 8'h80 >> i, 4'h1);
			chk("power enables", 3'b100 >> i, {adc_en, dac_en, mic_en});
		end
		wr(IDX_CH_PWR, 8'he0, 4'h1);
		wr(IDX_CH_PWR, 8'h00, 4'h0);
		rd(IDX_CH_PWR);
		chk("masked write", 8'he0, got);
		run <= 1'b1;
		wait (frames == 2);
		chk("record slot", 16'h9c3a, rec_word);
		chk("record oe bits", 32, oe_cnt);
		chk("line out left", 16'h7001, dl);
		chk("line out right idle", 16'h0, dr);
		@(posedge aclk);
		wr(IDX_IN_EN, 8'h01, 4'h1);
		wr(IDX_PLAY_SLOT0, 8'h81, 4'h1);
		wait (frames == 4);
		chk("disabled input", 16'h0, rec_word);
		chk("line out right", 16'h7001, dr);
		@(posedge aclk);
		run <= 1'b0;
		wait (frames == 5);
		@(posedge aclk);
		wr(IDX_SLEEP, 8'h01, 4'h1);
		poll(ST_SLEEP);
		chk("powered down", 3'b000, {adc_en, dac_en, mic_en});
		rd(IDX_IN_EN);
		chk("kept enable", 8'h01, got);
		rd(IDX_CH_PWR);
		chk("kept power", 8'he0, got);
		wr(IDX_SLEEP, 8'h00, 4'h1);
		poll(ST_ACTIVE);
		chk("resumed power", 3'b111, {adc_en, dac_en, mic_en});
		wr(IDX_SOFT_RESET, 8'h01, 4'h1);
		rd(IDX_STATUS);
		chk("reinit", ST_INIT, got[7:5]);
		poll(ST_SLEEP);
		rd(IDX_CH_PWR);
		chk("default power", CH_PWR_RST, got);
		chk("outputs off", 3'b000, {adc_en, dac_en, mic_en});
		chk("line out idle", 16'h0, dl);
		report_and_stop();
	end
endmodule
